// ===== common/timer_consts.svh
// Constants of the timer base with its channel 0 capture/compare unit.
// Assumes a 32-bit APB register bus with a 12-bit byte address.
// Functional notes
// - Readable writable 16-bit counter, cleared at reset.
// - Counter clock is input divided by prescale+1.
// - 16-bit reload value, resets to all ones.
// - 8-bit repetition value sets compare update rate.
// - Output mode compares value with counter for reference.
// - Input mode captures counter on capture event.
// - Capture flag set on capture, cleared by software/read.
// - Over-capture flag when capture finds flag set.
// - Compare flag on match, not in center mode.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define TB_ADDR_W       12
`define TB_OFF_COUNT    12'h080
`define TB_OFF_PRESCALE 12'h084
`define TB_OFF_RELOAD   12'h088
`define TB_OFF_REPEAT   12'h08C
`define TB_OFF_CH0_CC   12'h090
`define TB_OFF_CONTROL  12'h0C0
`define TB_OFF_STATUS   12'h0C4
`define TB_OFF_MASK     12'h0C8
`define TB_RST_COUNT    16'h0000
`define TB_RST_PRESCALE 16'h0000
`define TB_RST_RELOAD   16'hFFFF
`define TB_RST_REPEAT   8'h00
`define TB_RST_CH0_CC   16'h0000
`define TB_CTL_ENABLE   0
`define TB_CTL_INPUT    1
`define TB_CTL_CENTER   2
`define TB_ST_CCIF      0
`define TB_ST_OCF       4
`define TB_ST_UEV       8
`define TB_ST_W         9
`endif

// ===== common/timer_pkg.sv
// Types shared by the timer base design files.
// Assumes timer_consts.svh is available on the include path.
`include "timer_consts.svh"
package timer_pkg;
  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [`TB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } apb_req_s;

  typedef struct packed {
    logic center;
    logic ch0_input;
    logic enable;
  } ctl_s;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ACCESS = 2'b01
  } apb_state_e;
endpackage

// ===== verilog/prescale_div.sv
// Prescaler that turns the prescaler input clock into counter steps.
// Assumes the prescaler input clock is pclk itself.
`timescale 1ns/1ns
module prescale_div #(
  parameter int PSC_W = 16
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control.
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [PSC_W-1:0] psc,
  // Counter step.
  output logic                  tick
);
  logic [PSC_W-1:0] div_q;
  logic             tick_q;

  generate
    if (PSC_W < 1 || PSC_W > 32) begin : g_bad_width
      $error("prescale_div: PSC_W must lie in 1..32.");
    end
  endgenerate

  // One step every psc+1 input clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (restart || !run) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q >= psc) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule

// ===== verilog/timer_base.sv
// Timer base with counter, prescaler, reload, repetition and channel 0.
// Assumes an APB master on pclk and a capture input synchronous to pclk.
`timescale 1ns/1ns
`include "timer_consts.svh"
module timer_base #(
  parameter int CNT_W = 16,
  parameter int PSC_W = 16,
  parameter int REP_W = 8
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  timer_pkg::apb_req_s    apb_req,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Channel 0.
  input  wire logic              chan0_capture_in,
  output logic                   chan0_reference_output,
  // Events.
  output logic                   update_event,
  output logic                   irq
);
  timer_pkg::apb_state_e  apb_q;
  timer_pkg::ctl_s        ctl_q;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic                   dir_q;
  logic                   dir_d;
  logic [PSC_W-1:0]       psc_q;
  logic [CNT_W-1:0]       reload_q;
  logic [REP_W-1:0]       rep_val_q;
  logic [REP_W-1:0]       rep_q;
  logic [CNT_W-1:0]       ccr_q;
  logic [CNT_W-1:0]       ccr_act_q;
  logic [`TB_ST_W-1:0]    status_q;
  logic [`TB_ST_W-1:0]    status_d;
  logic [`TB_ST_W-1:0]    mask_q;
  logic [`TB_ST_W-1:0]    st_set;
  logic [`TB_ST_W-1:0]    st_clr;
  logic [31:0]            prdata_q;
  logic [31:0]            rd_data;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   ref_q;
  logic                   uev_q;
  logic                   irq_q;
  logic                   cap_prev_q;
  logic                   capture;
  logic                   tick;
  logic                   step;
  logic                   wrap;
  logic                   upd;
  logic                   match;
  logic                   mapped;
  logic                   done;
  logic                   wr_en;
  logic                   rd_en;
  logic [`TB_ADDR_W-1:0]  addr;
  logic [31:0]            wdata;

  generate
    if (CNT_W < 2 || CNT_W > 32 || REP_W < 1 || REP_W > 32) begin : g_bad_width
      $error("timer_base: CNT_W must lie in 2..32 and REP_W in 1..32.");
    end
    if (PSC_W < 1 || PSC_W > 32) begin : g_bad_psc
      $error("timer_base: PSC_W must lie in 1..32.");
    end
  endgenerate

  assign addr  = apb_req.paddr;
  assign wdata = apb_req.pwdata;

  // Address decode of the mapped words.
  always_comb begin
    case (addr)
      `TB_OFF_COUNT,
      `TB_OFF_PRESCALE,
      `TB_OFF_RELOAD,
      `TB_OFF_REPEAT,
      `TB_OFF_CH0_CC,
      `TB_OFF_CONTROL,
      `TB_OFF_STATUS,
      `TB_OFF_MASK: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
  end

  // Read data multiplexer; reserved bits read as zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (addr)
      `TB_OFF_COUNT:    rd_data[CNT_W-1:0]    = cnt_q;
      `TB_OFF_PRESCALE: rd_data[PSC_W-1:0]    = psc_q;
      `TB_OFF_RELOAD:   rd_data[CNT_W-1:0]    = reload_q;
      `TB_OFF_REPEAT:   rd_data[REP_W-1:0]    = rep_val_q;
      `TB_OFF_CH0_CC:   rd_data[CNT_W-1:0]    = ccr_q;
      `TB_OFF_CONTROL:  rd_data[2:0]          = ctl_q;
      `TB_OFF_STATUS:   rd_data[`TB_ST_W-1:0] = status_q;
      `TB_OFF_MASK:     rd_data[`TB_ST_W-1:0] = mask_q;
      default:          rd_data               = 32'h0000_0000;
    endcase
  end

  // The transfer completes at the first edge of its access phase.
  assign done  = (apb_q == timer_pkg::APB_ACCESS) && apb_req.psel && apb_req.penable;
  assign wr_en = done && apb_req.pwrite && !pslverr_q;
  assign rd_en = done && !apb_req.pwrite && !pslverr_q;

  // APB phase tracking with one wait-free access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q     <= timer_pkg::APB_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      case (apb_q)
        timer_pkg::APB_IDLE: begin
          if (apb_req.psel && !apb_req.penable) begin
            apb_q     <= timer_pkg::APB_ACCESS;
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q  <= (mapped && !apb_req.pwrite) ? rd_data : 32'h0000_0000;
          end
        end
        timer_pkg::APB_ACCESS: begin
          if (done) begin
            apb_q     <= timer_pkg::APB_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
          end
        end
        default: begin
          apb_q    <= timer_pkg::APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers written by software, one word each.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= PSC_W'(`TB_RST_PRESCALE);
    end else if (wr_en && addr == `TB_OFF_PRESCALE) begin
      psc_q <= wdata[PSC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= CNT_W'(`TB_RST_RELOAD);
    end else if (wr_en && addr == `TB_OFF_RELOAD) begin
      reload_q <= wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_val_q <= REP_W'(`TB_RST_REPEAT);
    end else if (wr_en && addr == `TB_OFF_REPEAT) begin
      rep_val_q <= wdata[REP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
    end else if (wr_en && addr == `TB_OFF_CONTROL) begin
      ctl_q <= timer_pkg::ctl_s'(wdata[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_en && addr == `TB_OFF_MASK) begin
      mask_q <= wdata[`TB_ST_W-1:0];
    end
  end

  prescale_div #(
    .PSC_W   (PSC_W)
  ) u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctl_q.enable),
    .restart (wr_en && addr == `TB_OFF_COUNT),
    .psc     (psc_q),
    .tick    (tick)
  );

  assign step = ctl_q.enable && tick;

  // Counter next value, edge-aligned up or center-aligned up/down.
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    wrap  = 1'b0;
    if (step) begin
      if (!ctl_q.center) begin
        if (cnt_q >= reload_q) begin
          cnt_d = '0;
          wrap  = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end else if (!dir_q) begin
        if (cnt_q >= reload_q) begin
          cnt_d = (reload_q == '0) ? cnt_q : cnt_q - 1'b1;
          dir_d = 1'b1;
          wrap  = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end else begin
        if (cnt_q == '0) begin
          cnt_d = (reload_q == '0) ? cnt_q : cnt_q + 1'b1;
          dir_d = 1'b0;
          wrap  = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    end
    if (wr_en && addr == `TB_OFF_COUNT) begin
      cnt_d = wdata[CNT_W-1:0];
    end
  end

  // Live counter value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_W'(`TB_RST_COUNT);
      dir_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= ctl_q.center ? dir_d : 1'b0;
    end
  end

  // Repetition countdown; a wrap with the countdown at zero raises an update and reloads it.
  assign upd = wrap && (rep_q == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_q <= REP_W'(`TB_RST_REPEAT);
    end else if (wrap) begin
      if (rep_q == '0) begin
        rep_q <= rep_val_q;
      end else begin
        rep_q <= rep_q - 1'b1;
      end
    end
  end

  // Capture input edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= chan0_capture_in;
    end
  end

  assign capture = ctl_q.ch0_input && chan0_capture_in && !cap_prev_q;

  // Channel 0 value and its active compare copy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_q     <= CNT_W'(`TB_RST_CH0_CC);
      ccr_act_q <= CNT_W'(`TB_RST_CH0_CC);
    end else begin
      if (capture) begin
        ccr_q <= cnt_q;
      end else if (wr_en && addr == `TB_OFF_CH0_CC) begin
        ccr_q <= wdata[CNT_W-1:0];
      end
      if (upd) begin
        ccr_act_q <= ccr_q;
      end
    end
  end

  // Compare match on a counter step, suppressed in center mode.
  assign match = step && !ctl_q.ch0_input && !ctl_q.center && (cnt_d == ccr_act_q);

  // In output mode the reference output is high while the counter is below the compare value; in input mode it is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= !ctl_q.ch0_input && (cnt_d < ccr_act_q);
    end
  end

  // Status flags: software writes one to clear, hardware set wins.
  always_comb begin
    st_set = '0;
    st_clr = '0;
    if (wr_en && addr == `TB_OFF_STATUS) begin
      st_clr = wdata[`TB_ST_W-1:0];
    end
    if (rd_en && addr == `TB_OFF_CH0_CC && ctl_q.ch0_input) begin
      st_clr[`TB_ST_CCIF] = 1'b1;
    end
    st_set[`TB_ST_CCIF] = capture || match;
    st_set[`TB_ST_OCF]  = capture && status_q[`TB_ST_CCIF] && !st_clr[`TB_ST_CCIF];
    st_set[`TB_ST_UEV]  = upd;
  end

  // Each flag keeps its value unless set or cleared; a set beats a clear.
  generate
    for (genvar b = 0; b < `TB_ST_W; b++) begin : g_status
      assign status_d[b] = st_set[b] || (status_q[b] && !st_clr[b]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Interrupt and update event outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      uev_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
      uev_q <= upd;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign chan0_reference_output = ref_q;
  assign update_event           = uev_q;
  assign irq                    = irq_q;
endmodule

// ===== testbench/timer_base_monitor.sv
// Checker of the timer base bus answers and event outputs.
// Assumes the timer_base ports and control, mask at 0x0C0, 0x0C8.
`timescale 1ns/1ns
module timer_base_monitor (
  // Clock and reset.
  input wire logic           pclk,
  input wire logic           presetn,
  // Bus.
  input timer_pkg::apb_req_s apb_req,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Channel and events.
  input wire logic           chan0_capture_in,
  input wire logic           chan0_reference_output,
  input wire logic           update_event,
  input wire logic           irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       ctl_in_q;
  logic [8:0] mask_q;
  wire        wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_in_q <= 1'b0;
    end else if (wr_done && apb_req.paddr == 12'h0C0) begin
      ctl_in_q <= apb_req.pwdata[1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 9'h000;
    end else if (wr_done && apb_req.paddr == 12'h0C8) begin
      mask_q <= apb_req.pwdata[8:0] & 9'h111;
    end
  end
  property p_ready_after_setup;
    apb_req.psel && !apb_req.penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("answer too long");
  property p_err_decode;
    pready |-> pslverr == !(apb_req.paddr inside {12'h080, 12'h084, 12'h088, 12'h08C,
      12'h090, 12'h0C0, 12'h0C4, 12'h0C8});
  endproperty
  a_err_decode: assert property (p_err_decode) else $error("bad error flag");
  property p_rdata_idle;
    !pready |-> prdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_rsvd_zero;
    pready && !apb_req.pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
  property p_rep_width;
    pready && !apb_req.pwrite && apb_req.paddr == 12'h08C |-> prdata[31:8] == 24'h000000;
  endproperty
  a_rep_width: assert property (p_rep_width) else $error("repetition too wide");
  property p_upd_pulse;
    update_event |=> !update_event;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
  property p_ref_input;
    ctl_in_q [*3] |-> !chan0_reference_output;
  endproperty
  a_ref_input: assert property (p_ref_input) else $error("reference in input");
  property p_irq_mask;
    (mask_q == 9'h000) [*2] |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_capture_irq;
    ctl_in_q && mask_q[0] && chan0_capture_in && !$past(chan0_capture_in) |=> irq;
  endproperty
  a_capture_irq: assert property (p_capture_irq) else $error("no irq on capture");
endmodule
bind timer_base timer_base_monitor u_timer_base_monitor (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan0_capture_in(chan0_capture_in),
  .chan0_reference_output(chan0_reference_output), .update_event(update_event), .irq(irq));

// ===== testbench/timer_base_tb.sv
// Self-checking bench of the timer base over APB.
// Assumes the checker is bound to timer_base.
`timescale 1ns/1ns
`include "timer_consts.svh"
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, x, g); end end
module timer_base_tb;
  logic                pclk;
  logic                presetn;
  timer_pkg::apb_req_s apb_req;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                cap;
  logic                ref_o;
  logic                upd;
  logic                irq;
  int                  n_errors;
  int                  cmp_count;
  int                  k;
  logic [31:0]         q;
  logic [31:0]         c1;
  logic                e;
  logic [11:0]         ra[5] = '{12'h080, 12'h084, 12'h088, 12'h08C, 12'h090};
  logic [31:0]         rv[5] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0};
  logic [31:0]         rm[5] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFF, 32'hFFFF};
  logic [31:0]         pv[3] = '{32'h0, 32'h2, 32'h5};
  timer_base u_timer_base (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan0_capture_in(cap), .chan0_reference_output(ref_o),
    .update_event(upd), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK($sformatf("read %h", a), x, q)
  endtask
  task automatic pulse;
    @(posedge pclk);
    cap <= 1'b1;
    repeat (2) @(posedge pclk);
    cap <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic gap(input int lim);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (upd !== 1'b1 && k < lim);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end
  initial begin
    apb_req = '0;
    cap = 1'b0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (ra[i]) begin
      wr(ra[i], 32'hFFFFFFFF);
      rd(ra[i], rm[i]);
    end
    apb(12'h0FC, 1'b0, 32'h0);
    `CHK("slverr", 1'b1, e)
    wr(`TB_OFF_CONTROL, 32'h1);
    foreach (pv[i]) begin
      wr(`TB_OFF_PRESCALE, pv[i]);
      wr(`TB_OFF_COUNT, 32'h0);
      repeat (8) @(posedge pclk);
      apb(`TB_OFF_COUNT, 1'b0, 32'h0);
      c1 = q;
      repeat (3) @(posedge pclk);
      rd(`TB_OFF_COUNT, c1 + 6 / (pv[i] + 1));
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TB_OFF_COUNT, 32'h0);
    rd(`TB_OFF_REPEAT, 32'h0);
    wr(`TB_OFF_CONTROL, 32'h0);
    wr(`TB_OFF_PRESCALE, 32'h0);
    wr(`TB_OFF_RELOAD, 32'h4);
    wr(`TB_OFF_REPEAT, 32'h2);
    wr(`TB_OFF_CH0_CC, 32'h3);
    wr(`TB_OFF_COUNT, 32'h0);
    wr(`TB_OFF_MASK, 32'h1);
    wr(`TB_OFF_CONTROL, 32'h1);
    gap(100);
    gap(100);
    `CHK("update gap", 15, k)
    k = 0;
    repeat (15) @(posedge pclk) k += ref_o;
    `CHK("ref high", 9, k)
    apb(`TB_OFF_STATUS, 1'b0, 32'h0);
    `CHK("cmp flag", 1'b1, q[0])
    `CHK("irq", 1'b1, irq)
    wr(`TB_OFF_CONTROL, 32'h0);
    wr(`TB_OFF_STATUS, 32'h111);
    rd(`TB_OFF_STATUS, 32'h0);
    wr(`TB_OFF_CONTROL, 32'h5);
    repeat (40) @(posedge pclk);
    wr(`TB_OFF_CONTROL, 32'h0);
    apb(`TB_OFF_STATUS, 1'b0, 32'h0);
    `CHK("center flag", 1'b0, q[0])
    `CHK("irq", 1'b0, irq)
    wr(`TB_OFF_STATUS, 32'h111);
    wr(`TB_OFF_CONTROL, 32'h2);
    wr(`TB_OFF_COUNT, 32'h1234);
    pulse();
    rd(`TB_OFF_STATUS, 32'h1);
    `CHK("irq", 1'b1, irq)
    wr(`TB_OFF_COUNT, 32'h55);
    pulse();
    rd(`TB_OFF_STATUS, 32'h11);
    rd(`TB_OFF_CH0_CC, 32'h55);
    rd(`TB_OFF_STATUS, 32'h10);
    wr(`TB_OFF_STATUS, 32'h10);
    rd(`TB_OFF_STATUS, 32'h0);
    conclude();
  end
endmodule
